// *** include/wdmc_regs.svh ***
`ifndef WDMC_REGS_SVH
`define WDMC_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define WDMC_ADDR_CTRL 4'h0
`define WDMC_ADDR_CAUSE 4'h1
`define WDMC_ADDR_IRQ_STAT 4'h2
`define WDMC_ADDR_IRQ_MASK 4'h3

// ----------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------
`define WDMC_BIT_FLAG 7
`define WDMC_BIT_IE 6
`define WDMC_BIT_PS3 5
`define WDMC_BIT_UNLOCK 4
`define WDMC_BIT_RE 3
`define WDMC_BIT_CAUSE 3
`define WDMC_BIT_RESTART 0

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define WDMC_EV_TIMEOUT 0
`define WDMC_EV_RESET 1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define WDMC_CTRL_RESET 8'h00
`define WDMC_UNLOCK_CYCLES 3'h4
`define WDMC_BASE_COUNT 21'h000800
`define WDMC_MAX_CODE 4'h9

`endif

// *** include/wdmc_pkg.sv ***
package wdmc_pkg;

  // Watchdog operating mode
  typedef enum logic [4:0] {
    WDMC_STOPPED = 5'h01,
    WDMC_IRQ = 5'h02,
    WDMC_RESET = 5'h04,
    WDMC_IRQ_RESET = 5'h08,
    WDMC_FORCED = 5'h10
  } wdmc_mode_t;

  // Configuration carried to the counter
  typedef struct packed {
    logic run;
    logic [3:0] period;
  } wdmc_cfg_t;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } wdmc_bus_t;

endpackage

// *** rtl/wdmc_sync.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser; first stage is read only by the second
module wdmc_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic d,
  output logic q
);
  logic meta_reg;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// *** rtl/wdmc_counter.sv ***
`timescale 1ns/1ns
`include "wdmc_regs.svh"
// Counts watchdog oscillator ticks and flags a time-out
module wdmc_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire wdmc_pkg::wdmc_cfg_t cfg,
  input wire logic tick,
  input wire logic restart,
  // Result
  output logic timeout
);
  logic [20:0] count_reg;
  logic [20:0] limit;
  logic [3:0] code;

  // Reserved codes fold onto the longest period
  // reserved code fold
  assign code = (cfg.period > `WDMC_MAX_CODE) ? `WDMC_MAX_CODE : cfg.period;
  assign limit = `WDMC_BASE_COUNT << code;

  // ----------------------------------------------------------------
  // Tick counter
  // ----------------------------------------------------------------
  // count oscillator ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 21'h000000;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (restart || !cfg.run) begin
        count_reg <= 21'h000000;
      end else if (tick) begin
        if (count_reg + 21'h000001 >= limit) begin
          count_reg <= 21'h000000;
          timeout <= 1'b1;
        end else begin
          count_reg <= count_reg + 21'h000001;
        end
      end
    end
  end
endmodule

// *** rtl/wdmc_top.sv ***
`timescale 1ns/1ns
`include "wdmc_regs.svh"
//
// Contract
// - Irq enable, global enable, no reset enable: interrupt on every time-out.
// - Both enables: first time-out sets flag and interrupts, no reset.
// - Taking the vector in that mode clears irq enable and flag.
// - Unserviced interrupt at next time-out in that mode resets the system.
// - Reset/irq enable pair selects stopped, interrupt, reset or combined.
// - Clearing reset enable or changing period needs the unlock bit.
// - Hardware clears the unlock bit four clocks after it is written.
// - Reset-cause flag forces reset enable set; clear cause first.
// - Period select is bit 5 plus bits 2..0.
// - Codes 0 to 9 give 2048 doubling up to 1048576 ticks.
// - Counter counts ticks of the separate watchdog oscillator.
// - Always-on fuse forces reset mode, reset enable 1, irq enable 0.
// - Time-out flag cleared by the vector or by writing one.
//
module wdmc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Core side
  input wire logic global_irq_en,
  input wire logic vector_taken,
  input wire logic wdr_pulse,
  // Pins and fuse
  input wire logic osc_clk_pin,
  input wire logic always_on_fuse,
  // Outputs
  output logic wd_irq_req,
  output logic wd_system_reset,
  output logic irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic rst_a_reg, rst_n;
  logic osc_s, osc_d_reg, tick;
  logic fuse_s;
  logic wd_irq_enable_reg, wd_irq_enable_next;
  logic wd_reset_enable_reg, wd_reset_enable_next;
  logic wd_change_unlock_reg, wd_change_unlock_next;
  logic wd_timeout_flag_reg, wd_timeout_flag_next;
  logic wd_reset_cause_flag_reg, wd_reset_cause_flag_next;
  logic [3:0] wd_period_select_reg, wd_period_select_next;
  logic [2:0] unlock_cnt_reg, unlock_cnt_next;
  logic [1:0] stat_reg, stat_next, mask_reg;
  logic [7:0] rdata_next;
  logic timeout, eff_re, eff_ie, wr_ctrl, wr_cause, unlocked;
  logic fire_irq, fire_reset;
  logic [3:0] wr_period;
  wdmc_pkg::wdmc_mode_t mode;
  wdmc_pkg::wdmc_cfg_t cfg;
  wdmc_pkg::wdmc_bus_t bus;

  // Packing of the control/status byte for reads
  function automatic logic [7:0] pack_ctrl(input logic flag, input logic ie,
                                           input logic [3:0] ps, input logic unl,
                                           input logic re);
    pack_ctrl = {flag, ie, ps[3], unl, re, ps[2:0]};
  endfunction

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_a_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n <= rst_a_reg;
    end
  end

  wdmc_sync u_osc_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(osc_clk_pin),
    .q(osc_s)
  );

  wdmc_sync u_fuse_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(always_on_fuse),
    .q(fuse_s)
  );

  // Rising edge of the slow oscillator, sampled after synchronising
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_d_reg <= 1'b0;
    end else begin
      osc_d_reg <= osc_s;
    end
  end
  assign tick = osc_s & ~osc_d_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign bus = '{wr: wr_en, rd: rd_en, addr: addr, wdata: wdata};
  assign wr_ctrl = bus.wr && (bus.addr == `WDMC_ADDR_CTRL);
  assign wr_cause = bus.wr && (bus.addr == `WDMC_ADDR_CAUSE);
  assign wr_period = {bus.wdata[`WDMC_BIT_PS3], bus.wdata[2:0]};
  assign unlocked = wd_change_unlock_reg;

  // ----------------------------------------------------------------
  // Effective mode
  // ----------------------------------------------------------------
  // cause flag forces reset enable; fuse override
  assign eff_re = fuse_s | wd_reset_cause_flag_reg | wd_reset_enable_reg;
  assign eff_ie = ~fuse_s & wd_irq_enable_reg;

  always_comb begin
    unique case ({fuse_s, eff_re, eff_ie})
      3'b000: mode = wdmc_pkg::WDMC_STOPPED;
      3'b001: mode = wdmc_pkg::WDMC_IRQ;
      3'b010: mode = wdmc_pkg::WDMC_RESET;
      3'b011: mode = wdmc_pkg::WDMC_IRQ_RESET;
      default: mode = wdmc_pkg::WDMC_FORCED;
    endcase
  end

  assign cfg = '{run: (mode != wdmc_pkg::WDMC_STOPPED), period: wd_period_select_reg};

  wdmc_counter u_counter (
    .clk(clk),
    .rst_n(rst_n),
    .cfg(cfg),
    .tick(tick),
    .restart(wdr_pulse),
    .timeout(timeout)
  );

  // Time-out actions per mode
  // first time-out only flags; unserviced means reset
  assign fire_reset = timeout && ((mode == wdmc_pkg::WDMC_RESET) ||
                                  (mode == wdmc_pkg::WDMC_FORCED) ||
                                  ((mode == wdmc_pkg::WDMC_IRQ_RESET) && wd_timeout_flag_reg));
  assign fire_irq = timeout && ((mode == wdmc_pkg::WDMC_IRQ) ||
                                ((mode == wdmc_pkg::WDMC_IRQ_RESET) && !wd_timeout_flag_reg));

  // ----------------------------------------------------------------
  // Control register next state
  // ----------------------------------------------------------------
  always_comb begin
    wd_irq_enable_next = wd_irq_enable_reg;
    wd_reset_enable_next = wd_reset_enable_reg;
    wd_change_unlock_next = wd_change_unlock_reg;
    wd_timeout_flag_next = wd_timeout_flag_reg;
    wd_reset_cause_flag_next = wd_reset_cause_flag_reg;
    wd_period_select_next = wd_period_select_reg;
    unlock_cnt_next = unlock_cnt_reg;
    if (wr_ctrl) begin
      wd_irq_enable_next = bus.wdata[`WDMC_BIT_IE];
      // Setting reset enable is always allowed
      if (bus.wdata[`WDMC_BIT_RE]) begin
        wd_reset_enable_next = 1'b1;
      end else if (unlocked && !wd_reset_cause_flag_reg) begin
        // clear only inside window; cause must be clear
        wd_reset_enable_next = 1'b0;
      end
      // period change only inside window; one write
      if (unlocked) begin
        wd_period_select_next = wr_period;
      end
      // write one to clear the flag
      if (bus.wdata[`WDMC_BIT_FLAG]) begin
        wd_timeout_flag_next = 1'b0;
      end
      if (bus.wdata[`WDMC_BIT_UNLOCK]) begin
        wd_change_unlock_next = 1'b1;
        unlock_cnt_next = `WDMC_UNLOCK_CYCLES;
      end else begin
        wd_change_unlock_next = 1'b0;
      end
    end else if (wd_change_unlock_reg) begin
      unlock_cnt_next = unlock_cnt_reg - 3'h1;
      if (unlock_cnt_reg == 3'h1) begin
        wd_change_unlock_next = 1'b0;
      end
    end
    if (vector_taken && wd_timeout_flag_reg) begin
      wd_timeout_flag_next = 1'b0;
      if (mode == wdmc_pkg::WDMC_IRQ_RESET) begin
        wd_irq_enable_next = 1'b0;
      end
    end
    // Hardware set wins over any clear
    if (fire_irq) begin
      wd_timeout_flag_next = 1'b1;
    end
    if (wr_cause && !bus.wdata[`WDMC_BIT_CAUSE]) begin
      wd_reset_cause_flag_next = 1'b0;
    end
    if (fire_reset) begin
      wd_reset_cause_flag_next = 1'b1;
    end
    if (fuse_s) begin
      wd_reset_enable_next = 1'b1;
      wd_irq_enable_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status; a read of the status clears it, set wins
  // ----------------------------------------------------------------
  always_comb begin
    stat_next = stat_reg;
    if (bus.rd && (bus.addr == `WDMC_ADDR_IRQ_STAT)) begin
      stat_next = 2'h0;
    end
    if (fire_irq) begin
      stat_next[`WDMC_EV_TIMEOUT] = 1'b1;
    end
    if (fire_reset) begin
      stat_next[`WDMC_EV_RESET] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `WDMC_ADDR_CTRL: rdata_next = pack_ctrl(wd_timeout_flag_reg, eff_ie,
                                                wd_period_select_reg,
                                                wd_change_unlock_reg, eff_re);
        `WDMC_ADDR_CAUSE: rdata_next = {4'h0, wd_reset_cause_flag_reg, 3'h0};
        `WDMC_ADDR_IRQ_STAT: rdata_next = {6'h00, stat_reg};
        `WDMC_ADDR_IRQ_MASK: rdata_next = {6'h00, mask_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_irq_enable_reg <= 1'b0;
      wd_reset_enable_reg <= 1'b0;
      wd_change_unlock_reg <= 1'b0;
      wd_timeout_flag_reg <= 1'b0;
      wd_reset_cause_flag_reg <= 1'b0;
      wd_period_select_reg <= 4'h0;
      unlock_cnt_reg <= 3'h0;
      stat_reg <= 2'h0;
    end else begin
      wd_irq_enable_reg <= wd_irq_enable_next;
      wd_reset_enable_reg <= wd_reset_enable_next;
      wd_change_unlock_reg <= wd_change_unlock_next;
      wd_timeout_flag_reg <= wd_timeout_flag_next;
      wd_reset_cause_flag_reg <= wd_reset_cause_flag_next;
      wd_period_select_reg <= wd_period_select_next;
      unlock_cnt_reg <= unlock_cnt_next;
      stat_reg <= stat_next;
    end
  end

  // Mask register and registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= 2'h0;
      rdata <= 8'h00;
      wd_irq_req <= 1'b0;
      wd_system_reset <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (bus.wr && (bus.addr == `WDMC_ADDR_IRQ_MASK)) begin
        mask_reg <= bus.wdata[1:0];
      end
      rdata <= rdata_next;
      // request needs global enable and irq enable
      wd_irq_req <= wd_timeout_flag_next & global_irq_en & eff_ie;
      wd_system_reset <= fire_reset;
      irq <= |(stat_next & mask_reg);
    end
  end
endmodule

// *** tb/wdmc_monitor.sv ***
`timescale 1ns/1ns
// Watches the register port and the watchdog outputs of the top module
module wdmc_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  // Core side and fuse
  input wire logic global_irq_en,
  input wire logic vector_taken,
  input wire logic always_on_fuse,
  // Watchdog outputs
  input wire logic wd_irq_req,
  input wire logic wd_system_reset
);
  logic [3:0] win_age;
  logic [3:0] rst_age;
  logic cause_live;
  wire ctrl_wr = wr_en && addr == 4'h0;
  // Age of the unlock window; a plain control write uses it up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      win_age <= 4'hF;
      rst_age <= 4'hF;
      cause_live <= 1'b0;
    end else begin
      win_age <= (ctrl_wr && wdata[4]) ? 4'h0 : ctrl_wr ? 4'hF : win_age + 4'(win_age != 4'hF);
      rst_age <= wd_system_reset ? 4'h0 : rst_age + 4'(rst_age != 4'hF);
      cause_live <= wd_system_reset || (cause_live && !(wr_en && addr == 4'h1 && !wdata[3]));
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_unlock_wr;
    ctrl_wr && wdata[4];
  endsequence
  sequence s_ctrl_rd;
    rd_en && addr == 4'h0;
  endsequence
  // Port behaviour, then the rules
  a_unmapped_zero: assert property (rd_en && addr > 4'h3 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_single: assert property (wd_system_reset |=> !wd_system_reset)
    else $error("system reset longer than one cycle");
  a_gie_gate: assert property (!global_irq_en ##1 !global_irq_en |=> !wd_irq_req)
    else $error("interrupt request without global enable");
  a_unlock_open: assert property (s_unlock_wr ##2 s_ctrl_rd |=> rdata[4])
    else $error("unlock bit not held");
  a_unlock_close: assert property (s_unlock_wr ##1 (!ctrl_wr)[*6] ##0 s_ctrl_rd |=> !rdata[4])
    else $error("unlock bit not cleared");
  a_period_layout: assert property (ctrl_wr && !wdata[4] && win_age <= 4'h1 ##2 s_ctrl_rd
    |=> {rdata[5], rdata[2:0]} == {$past(wdata[5], 3), $past(wdata[2:0], 3)})
    else $error("period select not taken in window");
  a_fuse_lock: assert property (always_on_fuse[*6] ##0 s_ctrl_rd |=> rdata[3] && !rdata[6])
    else $error("fuse does not lock enables");
  a_cause_forces: assert property ((cause_live && rst_age > 4'h4) ##0 s_ctrl_rd |=> rdata[3])
    else $error("reset enable not forced by cause");
  a_flag_clear: assert property ((vector_taken || ctrl_wr && wdata[7]) |-> ##2 !wd_irq_req)
    else $error("time-out flag not cleared");
endmodule

bind wdmc_top wdmc_monitor i_wdmc_monitor (.clk(clk), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .global_irq_en(global_irq_en),
  .vector_taken(vector_taken), .always_on_fuse(always_on_fuse), .wd_irq_req(wd_irq_req),
  .wd_system_reset(wd_system_reset));

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  logic clk = 0, resetn = 0, wr_en = 0, rd_en = 0, gie = 0, vec = 0, wdr = 0, osc = 0, fuse = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, q, v;
  logic wirq, wrst, irq;
  int fail_count = 0, total_checks = 0, cyc = 0, n, nrst = 0, seed = 32'h813d;
  wdmc_top i_wdmc_top (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .global_irq_en(gie), .vector_taken(vec), .wdr_pulse(wdr),
    .osc_clk_pin(osc), .always_on_fuse(fuse), .wd_irq_req(wirq), .wd_system_reset(wrst),
    .irq(irq));
  // Clock; oscillator at a quarter rate keeps time-outs short
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 2 == 1) osc <= ~osc;
    if (wrst) nrst <= nrst + 1;
    if (cyc == 70000) begin
      fail_count++;
      test_done;
    end
  end
  // Clock cycles until a time-out for a period code
  function automatic int tmo(input int code);
    return (2048 << code) * 4;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus cycles, one strobe cycle each
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic strobe(input bit is_vec);
    @(posedge clk);
    if (is_vec) vec <= 1'b1;
    else wdr <= 1'b1;
    @(posedge clk);
    vec <= 1'b0;
    wdr <= 1'b0;
  endtask
  // Bounded wait for the request or the reset output
  task automatic wait_out(input bit rs);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (!(rs ? wrst : wirq) && n < 12000);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 4; a++) begin
      rd(a[3:0]);
      chk("reset_val", q, 8'h00);
    end
    wr(4'h9, 8'hFF);
    rd(4'hF);
    chk("unmapped", q, 8'h00);
    wr(4'h0, 8'h18);
    rd(4'h0);
    chk("unlock_open", q, 8'h18);
    wr(4'h0, 8'h18);
    repeat (4) @(posedge clk);
    rd(4'h0);
    chk("unlock_shut", q, 8'h08);
    // Interrupt mode with both events unmasked
    wr(4'h3, 8'h03);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h40);
    gie <= 1'b1;
    strobe(1'b0);
    wait_out(1'b0);
    chk("irq_len", 8'(n > tmo(0) - 16 && n < tmo(0) + 16), 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("irq_line", {7'h0, irq}, 8'h01);
    // Request must follow the global enable while the flag stays set
    @(posedge clk);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("gie_gate", {7'h0, wirq}, 8'h00);
    @(posedge clk);
    gie <= 1'b1;
    rd(4'h2);
    chk("status", q, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("irq_drop", {7'h0, irq}, 8'h00);
    wr(4'h0, 8'hC0);
    rd(4'h0);
    chk("flag_w1c", q | {wirq, 7'h0}, 8'h40);
    // Combined mode: interrupt, vector, then reset
    wr(4'h0, 8'h48);
    strobe(1'b0);
    v = 8'(nrst);
    wait_out(1'b0);
    chk("no_early_rst", 8'(nrst), v);
    strobe(1'b1);
    rd(4'h0);
    chk("vector_clr", q, 8'h08);
    wait_out(1'b1);
    chk("rst_mode", {7'h0, wrst}, 8'h01);
    rd(4'h1);
    chk("cause", q, 8'h08);
    rd(4'h2);
    chk("status2", q, 8'h03);
    wr(4'h0, 8'h48);
    strobe(1'b0);
    wait_out(1'b0);
    chk("rearm", {7'h0, wirq}, 8'h01);
    wait_out(1'b1);
    chk("unserviced", {7'h0, wrst}, 8'h01);
    wr(4'h0, 8'h88);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk("cause_hold", q, 8'h08);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk("re_clear", q, 8'h00);
    // Period codes: both ends, then random ones
    for (int i = 0; i < 10; i++) begin
      n = (i < 2) ? i * 9 : ($random(seed) & 32'h7FFFFFFF) % 10;
      v = {2'b00, n[3], 2'b00, n[2:0]};
      wr(4'h0, 8'h18);
      wr(4'h0, v);
      rd(4'h0);
      chk("period", q, v);
    end
    wr(4'h0, 8'h0A);
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk("locked", q, v | 8'h08);
    fuse <= 1'b1;
    repeat (8) @(posedge clk);
    rd(4'h0);
    chk("fuse_lock", q & 8'h48, 8'h08);
    // Forced mode must end in a system reset; shortest period keeps it quick
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h08);
    strobe(1'b0);
    wait_out(1'b1);
    chk("fuse_reset", {7'h0, wrst}, 8'h01);
    test_done;
  end
endmodule
